// ==== verilog/dual_timer_pkg.sv ====
// constants for the dual 8-bit timer/capture block
// assumes a byte-wide register port with a 4-bit address
package dual_timer_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL0  = 4'h0;
  localparam logic [3:0] ADDR_DATA0  = 4'h1;
  localparam logic [3:0] ADDR_CTRL1  = 4'h2;
  localparam logic [3:0] ADDR_DATA1  = 4'h3;
  localparam logic [3:0] ADDR_EXTIRQ = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_MASK   = 4'h6;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN    = 0;
  localparam int CTRL_SEL    = 1;
  localparam int CTRL0_CAP   = 4;
  localparam int CTRL1_CAP   = 3;
  localparam int CTRL1_WIDE  = 4;
  localparam int CTRL_CLR    = 5;
  localparam int EXT_POL     = 0;
  localparam int EXT_BOTH    = 2;
  localparam int ST_MATCH0   = 0;
  localparam int ST_MATCH1   = 1;
  localparam int ST_FIRST_TIMER_CAPTURE_ENABLE     = 2;
  localparam int ST_SECOND_TIMER_CAPTURE_ENABLE     = 3;

  // ----------------------------------------------------------------
  // reset values and widths
  // ----------------------------------------------------------------
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [3:0]  NIB_RST  = 4'h0;
  localparam logic [1:0]  PAIR_RST = 2'h0;
  localparam logic [11:0] PRE_RST  = 12'h000;
  localparam int          PRE_W    = 12;

  // prescaler tap: the divider is 2 to the power of the tap
  localparam int TAP_DIV1    = 0;
  localparam int TAP_DIV2    = 1;
  localparam int TAP_DIV4    = 2;
  localparam int TAP_DIV16   = 4;
  localparam int TAP_DIV64   = 6;
  localparam int TAP_DIV256  = 8;
  localparam int TAP_DIV1024 = 10;
  localparam int TAP_DIV4096 = 12;

  typedef enum logic [2:0] {
    SEL0_DIV2    = 3'h0,
    SEL0_DIV4    = 3'h1,
    SEL0_DIV16   = 3'h2,
    SEL0_DIV64   = 3'h3,
    SEL0_DIV256  = 3'h4,
    SEL0_DIV1024 = 3'h5,
    SEL0_DIV4096 = 3'h6,
    SEL0_EXT     = 3'h7
  } first_sel_t;

  typedef enum logic [1:0] {
    SEL1_DIV1  = 2'h0,
    SEL1_DIV2  = 2'h1,
    SEL1_DIV16 = 2'h2,
    SEL1_OVF   = 2'h3
  } second_sel_t;

endpackage : dual_timer_pkg

// ==== verilog/dual_8bit_timer_capture.sv ====
// dual 8-bit timer/counter with compare match and capture
// assumes a synchronous register port and inputs synchronous to clk_i
// How it works
// - each timer has its own 8-bit counter and 8-bit compare register
// - first timer clocks at prescale 2..4096 or the external count input
// - second timer clocks at prescale 1, 2, 16 or first timer overflow
// - counters step on their clock; equal to compare raises the interrupt
// - external count input advances the first timer on rising edges
// - selecting the external count input turns its pin to input
// - the second timer cannot use the external count input
// - wide mode, low compare zero: match at high compare plus one
// - capture enable one selects capture mode with any clock source
// - match interrupt still works in capture mode
// - a capture event loads the current count into capture data
// - after capture the counter clears and restarts from zero
// - capture trigger is the external irq input, edge and polarity set
// - data address reads capture data in capture mode, else the counter
// - wide capture acts like 8-bit capture over 16 bits
`timescale 1ns/100ps
module dual_8bit_timer_capture (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       external_count_input_i,
  output logic            ext_count_pin_input_o,
  input  wire logic       first_external_irq_input_i,
  input  wire logic       second_external_irq_input_i,
  output logic            irq_o
);

  // ----------------------------------------------------------------
  // decoders
  // ----------------------------------------------------------------
  function automatic logic div_tick(
    input logic [dual_timer_pkg::PRE_W-1:0] pre,
    input int                               tap
  );
    logic [dual_timer_pkg::PRE_W-1:0] m;
    m = ~({dual_timer_pkg::PRE_W{1'b1}} << tap);
    div_tick = ((pre & m) == m);
  endfunction : div_tick

  // both=1 fires on either edge, else pol picks rising (1) or falling
  function automatic logic edge_hit(
    input logic now,
    input logic was,
    input logic pol,
    input logic both
  );
    edge_hit = both ? (now ^ was)
                    : (pol ? (now & ~was) : (~now & was));
  endfunction : edge_hit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [11:0] pre;
  logic        ec_prev;
  logic        irq0_prev;
  logic        irq1_prev;
  logic        run0;
  logic        run1;
  dual_timer_pkg::first_sel_t  first_timer_clock_select;
  dual_timer_pkg::second_sel_t second_timer_clock_select;
  logic        first_timer_capture_enable;
  logic        second_timer_capture_enable;
  logic        wide_mode_enable;
  logic [7:0]  first_timer_compare_data;
  logic [7:0]  second_timer_compare_data;
  logic [7:0]  first_timer_counter;
  logic [7:0]  second_timer_counter;
  logic [7:0]  first_timer_capture_data;
  logic [7:0]  second_timer_capture_data;
  logic [1:0]  ext_irq_polarity_select;
  logic [1:0]  ext_irq_edge_select;
  logic [3:0]  status;
  logic [3:0]  mask;

  logic [11:0] next_pre;
  logic        next_run0;
  logic        next_run1;
  dual_timer_pkg::first_sel_t  next_sel0;
  dual_timer_pkg::second_sel_t next_sel1;
  logic        next_capen0;
  logic        next_capen1;
  logic        next_wide;
  logic [7:0]  next_cmp0;
  logic [7:0]  next_cmp1;
  logic [7:0]  next_cnt0;
  logic [7:0]  next_cnt1;
  logic [7:0]  next_first_timer_capture_enable;
  logic [7:0]  next_second_timer_capture_enable;
  logic [1:0]  next_pol;
  logic [1:0]  next_both;
  logic [3:0]  next_status;
  logic [3:0]  next_mask;
  logic [7:0]  next_rdata;

  logic        tick0;
  logic        tick1;
  logic        ovf0;
  logic        trig0;
  logic        trig1;
  logic        cap_evt0;
  logic        cap_evt1;
  logic        clr0_wr;
  logic        clr1_wr;
  logic        match0_evt;
  logic        match1_evt;
  logic [7:0]  hi_target;
  logic        show_second_timer_capture_enable;

  // ----------------------------------------------------------------
  // clock selection
  // ----------------------------------------------------------------
  always_comb begin
    tick0 = 1'b0;
    case (first_timer_clock_select)
      dual_timer_pkg::SEL0_DIV2:
        tick0 = div_tick(pre, dual_timer_pkg::TAP_DIV2);
      dual_timer_pkg::SEL0_DIV4:
        tick0 = div_tick(pre, dual_timer_pkg::TAP_DIV4);
      dual_timer_pkg::SEL0_DIV16:
        tick0 = div_tick(pre, dual_timer_pkg::TAP_DIV16);
      dual_timer_pkg::SEL0_DIV64:
        tick0 = div_tick(pre, dual_timer_pkg::TAP_DIV64);
      dual_timer_pkg::SEL0_DIV256:
        tick0 = div_tick(pre, dual_timer_pkg::TAP_DIV256);
      dual_timer_pkg::SEL0_DIV1024:
        tick0 = div_tick(pre, dual_timer_pkg::TAP_DIV1024);
      dual_timer_pkg::SEL0_DIV4096:
        tick0 = div_tick(pre, dual_timer_pkg::TAP_DIV4096);
      dual_timer_pkg::SEL0_EXT:
        tick0 = external_count_input_i & ~ec_prev;
      default:
        tick0 = 1'b0;
    endcase
    tick0 = tick0 & run0;
    ovf0  = tick0 && (first_timer_counter == 8'hFF);
  end

  // the second timer has no path to the external count input
  always_comb begin
    tick1 = 1'b0;
    case (second_timer_clock_select)
      dual_timer_pkg::SEL1_DIV1:
        tick1 = div_tick(pre, dual_timer_pkg::TAP_DIV1);
      dual_timer_pkg::SEL1_DIV2:
        tick1 = div_tick(pre, dual_timer_pkg::TAP_DIV2);
      dual_timer_pkg::SEL1_DIV16:
        tick1 = div_tick(pre, dual_timer_pkg::TAP_DIV16);
      dual_timer_pkg::SEL1_OVF:
        tick1 = ovf0;
      default:
        tick1 = 1'b0;
    endcase
    tick1 = wide_mode_enable ? ovf0 : (tick1 & run1);
  end

  assign ext_count_pin_input_o =
    (first_timer_clock_select == dual_timer_pkg::SEL0_EXT);

  // ----------------------------------------------------------------
  // capture triggers and software clears
  // ----------------------------------------------------------------
  assign trig0 = edge_hit(first_external_irq_input_i, irq0_prev,
                          ext_irq_polarity_select[0],
                          ext_irq_edge_select[0]);
  assign trig1 = edge_hit(second_external_irq_input_i, irq1_prev,
                          ext_irq_polarity_select[1],
                          ext_irq_edge_select[1]);
  assign cap_evt0 = first_timer_capture_enable & trig0;
  // wide capture is triggered by the first input for both bytes
  assign cap_evt1 = wide_mode_enable ? cap_evt0
                  : (second_timer_capture_enable & trig1);
  assign clr0_wr = wr_i && (addr_i == dual_timer_pkg::ADDR_CTRL0)
                   && wdata_i[dual_timer_pkg::CTRL_CLR];
  assign clr1_wr = wr_i && (addr_i == dual_timer_pkg::ADDR_CTRL1)
                   && wdata_i[dual_timer_pkg::CTRL_CLR];

  // ----------------------------------------------------------------
  // compare match
  // ----------------------------------------------------------------
  // low compare zero pushes the high target one further on
  assign hi_target = (first_timer_compare_data == 8'h00)
                   ? second_timer_compare_data + 8'h01
                   : second_timer_compare_data;

  always_comb begin
    match0_evt = 1'b0;
    match1_evt = 1'b0;
    // a software clear is not a counting step, so it never matches
    if (wide_mode_enable) begin
      match0_evt = tick0 && !cap_evt0 && !clr0_wr && !clr1_wr
        && (first_timer_counter + 8'h01 == first_timer_compare_data)
        && ((ovf0 ? second_timer_counter + 8'h01
                  : second_timer_counter) == hi_target);
    end else begin
      match0_evt = tick0 && !cap_evt0 && !clr0_wr
        && (first_timer_counter + 8'h01
            == first_timer_compare_data);
      match1_evt = tick1 && !cap_evt1 && !clr1_wr
        && (second_timer_counter + 8'h01
            == second_timer_compare_data);
    end
  end

  // ----------------------------------------------------------------
  // counters and capture registers
  // ----------------------------------------------------------------
  always_comb begin
    next_pre  = pre + 12'h001;
    next_cnt0 = first_timer_counter;
    next_cnt1 = second_timer_counter;
    next_first_timer_capture_enable = first_timer_capture_data;
    next_second_timer_capture_enable = second_timer_capture_data;
    if (tick0) begin
      next_cnt0 = first_timer_counter + 8'h01;
    end
    if (tick1) begin
      next_cnt1 = second_timer_counter + 8'h01;
    end
    if (cap_evt0) begin
      next_first_timer_capture_enable = first_timer_counter;
      next_cnt0 = 8'h00;
    end
    if (cap_evt1) begin
      next_second_timer_capture_enable = second_timer_counter;
      next_cnt1 = 8'h00;
    end
    if (clr0_wr) begin
      next_cnt0 = 8'h00;
    end
    if (clr1_wr) begin
      next_cnt1 = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_comb begin
    next_run0   = run0;
    next_run1   = run1;
    next_sel0   = first_timer_clock_select;
    next_sel1   = second_timer_clock_select;
    next_capen0 = first_timer_capture_enable;
    next_capen1 = second_timer_capture_enable;
    next_wide   = wide_mode_enable;
    next_cmp0   = first_timer_compare_data;
    next_cmp1   = second_timer_compare_data;
    next_pol    = ext_irq_polarity_select;
    next_both   = ext_irq_edge_select;
    next_mask   = mask;
    if (wr_i) begin
      case (addr_i)
        dual_timer_pkg::ADDR_CTRL0: begin
          next_run0   = wdata_i[dual_timer_pkg::CTRL_RUN];
          next_sel0   = dual_timer_pkg::first_sel_t'(wdata_i[3:1]);
          next_capen0 = wdata_i[dual_timer_pkg::CTRL0_CAP];
        end
        dual_timer_pkg::ADDR_CTRL1: begin
          next_run1   = wdata_i[dual_timer_pkg::CTRL_RUN];
          next_sel1   = dual_timer_pkg::second_sel_t'(wdata_i[2:1]);
          next_capen1 = wdata_i[dual_timer_pkg::CTRL1_CAP];
          next_wide   = wdata_i[dual_timer_pkg::CTRL1_WIDE];
        end
        dual_timer_pkg::ADDR_DATA0:  next_cmp0 = wdata_i;
        dual_timer_pkg::ADDR_DATA1:  next_cmp1 = wdata_i;
        dual_timer_pkg::ADDR_EXTIRQ: begin
          next_pol  = wdata_i[1:0];
          next_both = wdata_i[3:2];
        end
        dual_timer_pkg::ADDR_MASK:   next_mask = wdata_i[3:0];
        default: next_mask = mask;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sticky status, write one to clear; a new event beats the clear
  // ----------------------------------------------------------------
  always_comb begin
    next_status = status;
    if (wr_i && (addr_i == dual_timer_pkg::ADDR_STATUS)) begin
      next_status = status & ~wdata_i[3:0];
    end
    next_status[dual_timer_pkg::ST_MATCH0] =
      next_status[dual_timer_pkg::ST_MATCH0] | match0_evt;
    next_status[dual_timer_pkg::ST_MATCH1] =
      next_status[dual_timer_pkg::ST_MATCH1] | match1_evt;
    next_status[dual_timer_pkg::ST_FIRST_TIMER_CAPTURE_ENABLE] =
      next_status[dual_timer_pkg::ST_FIRST_TIMER_CAPTURE_ENABLE] | cap_evt0;
    next_status[dual_timer_pkg::ST_SECOND_TIMER_CAPTURE_ENABLE] =
      next_status[dual_timer_pkg::ST_SECOND_TIMER_CAPTURE_ENABLE]
      | (cap_evt1 & ~wide_mode_enable);
  end

  assign irq_o = |(status & mask);

  // ----------------------------------------------------------------
  // read data, valid only in the cycle after the strobe
  // ----------------------------------------------------------------
  assign show_second_timer_capture_enable = wide_mode_enable ? first_timer_capture_enable
                                      : second_timer_capture_enable;

  always_comb begin
    next_rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        dual_timer_pkg::ADDR_CTRL0:
          next_rdata = {3'h0, first_timer_capture_enable,
                        first_timer_clock_select, run0};
        dual_timer_pkg::ADDR_DATA0:
          next_rdata = first_timer_capture_enable
                     ? first_timer_capture_data : first_timer_counter;
        dual_timer_pkg::ADDR_CTRL1:
          next_rdata = {3'h0, wide_mode_enable,
                        second_timer_capture_enable,
                        second_timer_clock_select, run1};
        dual_timer_pkg::ADDR_DATA1:
          next_rdata = show_second_timer_capture_enable
                     ? second_timer_capture_data : second_timer_counter;
        dual_timer_pkg::ADDR_EXTIRQ:
          next_rdata = {4'h0, ext_irq_edge_select,
                        ext_irq_polarity_select};
        dual_timer_pkg::ADDR_STATUS: next_rdata = {4'h0, status};
        dual_timer_pkg::ADDR_MASK:   next_rdata = {4'h0, mask};
        default:                     next_rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre                         <= dual_timer_pkg::PRE_RST;
      ec_prev                     <= 1'b0;
      irq0_prev                   <= 1'b0;
      irq1_prev                   <= 1'b0;
      run0                        <= 1'b0;
      run1                        <= 1'b0;
      first_timer_clock_select    <= dual_timer_pkg::SEL0_DIV2;
      second_timer_clock_select   <= dual_timer_pkg::SEL1_DIV1;
      first_timer_capture_enable  <= 1'b0;
      second_timer_capture_enable <= 1'b0;
      wide_mode_enable            <= 1'b0;
      first_timer_compare_data    <= dual_timer_pkg::BYTE_RST;
      second_timer_compare_data   <= dual_timer_pkg::BYTE_RST;
      first_timer_counter         <= dual_timer_pkg::BYTE_RST;
      second_timer_counter        <= dual_timer_pkg::BYTE_RST;
      first_timer_capture_data    <= dual_timer_pkg::BYTE_RST;
      second_timer_capture_data   <= dual_timer_pkg::BYTE_RST;
      ext_irq_polarity_select     <= dual_timer_pkg::PAIR_RST;
      ext_irq_edge_select         <= dual_timer_pkg::PAIR_RST;
      status                      <= dual_timer_pkg::NIB_RST;
      mask                        <= dual_timer_pkg::NIB_RST;
      rdata_o                     <= dual_timer_pkg::BYTE_RST;
    end else begin
      pre                         <= next_pre;
      ec_prev                     <= external_count_input_i;
      irq0_prev                   <= first_external_irq_input_i;
      irq1_prev                   <= second_external_irq_input_i;
      run0                        <= next_run0;
      run1                        <= next_run1;
      first_timer_clock_select    <= next_sel0;
      second_timer_clock_select   <= next_sel1;
      first_timer_capture_enable  <= next_capen0;
      second_timer_capture_enable <= next_capen1;
      wide_mode_enable            <= next_wide;
      first_timer_compare_data    <= next_cmp0;
      second_timer_compare_data   <= next_cmp1;
      first_timer_counter         <= next_cnt0;
      second_timer_counter        <= next_cnt1;
      first_timer_capture_data    <= next_first_timer_capture_enable;
      second_timer_capture_data   <= next_second_timer_capture_enable;
      ext_irq_polarity_select     <= next_pol;
      ext_irq_edge_select         <= next_both;
      status                      <= next_status;
      mask                        <= next_mask;
      rdata_o                     <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_ext_edge;
    run0 && first_timer_clock_select == dual_timer_pkg::SEL0_EXT
    && external_count_input_i && !ec_prev && !cap_evt0 && !clr0_wr
    |=> first_timer_counter == $past(first_timer_counter) + 8'h01;
  endproperty
  a_ext_edge: assert property (p_ext_edge)
    else $error("external edge did not advance the first timer");

  property p_ext_dir;
    first_timer_clock_select == dual_timer_pkg::SEL0_EXT
    <-> ext_count_pin_input_o;
  endproperty
  a_ext_dir: assert property (p_ext_dir)
    else $error("external count pin direction wrong");

  property p_div1;
    !wide_mode_enable && run1 && !cap_evt1 && !clr1_wr
    && second_timer_clock_select == dual_timer_pkg::SEL1_DIV1
    |=> second_timer_counter == $past(second_timer_counter) + 8'h01;
  endproperty
  a_div1: assert property (p_div1)
    else $error("second timer divide-by-one did not step");

  property p_div2_idle;
    run0 && !wide_mode_enable && !cap_evt0 && !clr0_wr
    && first_timer_clock_select == dual_timer_pkg::SEL0_DIV2
    && !pre[0] |=> first_timer_counter == $past(first_timer_counter);
  endproperty
  a_div2_idle: assert property (p_div2_idle)
    else $error("first timer stepped off its prescale tick");

  property p_match_irq;
    match0_evt && mask[dual_timer_pkg::ST_MATCH0]
    |=> irq_o && first_timer_counter == first_timer_compare_data;
  endproperty
  a_match_irq: assert property (p_match_irq)
    else $error("match did not raise the interrupt");

  property p_cap_load;
    cap_evt0 |=> first_timer_capture_data == $past(first_timer_counter)
                 && status[dual_timer_pkg::ST_FIRST_TIMER_CAPTURE_ENABLE];
  endproperty
  a_cap_load: assert property (p_cap_load)
    else $error("capture did not load the count");

  property p_cap_clear;
    cap_evt1 |=> second_timer_counter == 8'h00;
  endproperty
  a_cap_clear: assert property (p_cap_clear)
    else $error("counter not cleared after capture");

  property p_read_cap;
    rd_i && addr_i == dual_timer_pkg::ADDR_DATA0
    && first_timer_capture_enable
    |=> rdata_o == $past(first_timer_capture_data) ##1 rdata_o == 8'h00
        || $past(rd_i);
  endproperty
  a_read_cap: assert property (p_read_cap)
    else $error("capture-mode read returned the wrong source");

  property p_wide_quirk;
    wide_mode_enable && match0_evt && first_timer_compare_data == 8'h00
    |=> second_timer_counter == $past(second_timer_compare_data) + 8'h01
        && first_timer_counter == 8'h00;
  endproperty
  a_wide_quirk: assert property (p_wide_quirk)
    else $error("wide match with low compare zero off by one");

  property p_wide_carry;
    wide_mode_enable && ovf0 && !cap_evt0 && !clr0_wr && !clr1_wr
    |=> first_timer_counter == 8'h00
        && second_timer_counter == $past(second_timer_counter) + 8'h01;
  endproperty
  a_wide_carry: assert property (p_wide_carry)
    else $error("low overflow did not carry into the high byte");

  c_match8: cover property (!wide_mode_enable && match1_evt);
  c_capture: cover property (cap_evt0 ##[1:50] cap_evt0);
  c_wide_match: cover property (wide_mode_enable && match0_evt);
  c_ext_count: cover property (
    first_timer_clock_select == dual_timer_pkg::SEL0_EXT && tick0);

endmodule : dual_8bit_timer_capture

// ==== tb/dual_8bit_timer_capture_test.sv ====
// self-checking bench for the dual 8-bit timer/capture block
// assumes the register map and timing of dual_timer_pkg
`timescale 1ns/100ps
module dual_8bit_timer_capture_test;
  logic       clk_i;
  logic       rst_n_i;
  logic [3:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic       count_in;
  logic       pin_in;
  logic       trig0;
  logic       trig1;
  logic       irq_o;
  int         mismatches;
  int         tests_run;
  int         n;
  int         m;
  logic [7:0] d;

  dual_8bit_timer_capture dual_8bit_timer_capture_inst (
    .clk_i                       (clk_i),
    .rst_n_i                     (rst_n_i),
    .addr_i                      (addr_i),
    .wdata_i                     (wdata_i),
    .wr_i                        (wr_i),
    .rd_i                        (rd_i),
    .rdata_o                     (rdata_o),
    .external_count_input_i      (count_in),
    .ext_count_pin_input_o       (pin_in),
    .first_external_irq_input_i  (trig0),
    .second_external_irq_input_i (trig1),
    .irq_o                       (irq_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd

  task automatic chk(input string what, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // rising edges spaced four cycles apart, as a slow event source
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge clk_i); count_in <= 1'b1;
      repeat (2) @(posedge clk_i);
      count_in <= 1'b0;
      @(posedge clk_i);
    end
  endtask : pulse

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // hang guard well above the at most roughly 1650 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {addr_i, wdata_i, wr_i, rd_i, count_in, trig0, trig1} = '0;
    rst_n_i = 1'b0; mismatches = 0; tests_run = 0;
    n = $urandom(32'h9528);
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(a[3:0], d); chk("reset reg", 8'h00, d);
    end
    chk("reset irq", 8'h00, {7'h00, irq_o});
    $display("test reset done");
    n = $urandom_range(3, 40);
    wr(dual_timer_pkg::ADDR_DATA0, n[7:0]);
    wr(dual_timer_pkg::ADDR_MASK, 8'h05);
    wr(dual_timer_pkg::ADDR_CTRL0, 8'h0F);
    #1 chk("pin input", 8'h01, {7'h00, pin_in});
    pulse(n); rd(dual_timer_pkg::ADDR_DATA0, d);
    chk("count0", n[7:0], d);
    chk("match irq", 8'h01, {7'h00, irq_o});
    wr(dual_timer_pkg::ADDR_STATUS, 8'h01);
    #1 chk("irq cleared", 8'h00, {7'h00, irq_o});
    $display("test count and match done");
    m = $urandom_range(2, 60);
    wr(dual_timer_pkg::ADDR_EXTIRQ, 8'h01);
    wr(dual_timer_pkg::ADDR_CTRL0, 8'h3F);
    pulse(m);
    @(posedge clk_i); trig0 <= 1'b1;
    repeat (2) @(posedge clk_i);
    trig0 <= 1'b0;
    rd(dual_timer_pkg::ADDR_DATA0, d); chk("capture0", m[7:0], d);
    rd(dual_timer_pkg::ADDR_STATUS, d);
    chk("cap status", 8'h04 | ((m >= n) ? 8'h01 : 8'h00), d);
    pulse(3); wr(dual_timer_pkg::ADDR_CTRL0, 8'h0F);
    rd(dual_timer_pkg::ADDR_DATA0, d); chk("restart", 8'h03, d);
    $display("test capture done");
    wr(dual_timer_pkg::ADDR_STATUS, 8'hFF);
    wr(dual_timer_pkg::ADDR_DATA0, 8'h00);
    wr(dual_timer_pkg::ADDR_DATA1, 8'h00);
    wr(dual_timer_pkg::ADDR_CTRL1, 8'h36);
    wr(dual_timer_pkg::ADDR_CTRL0, 8'h2F);
    pulse(255); rd(dual_timer_pkg::ADDR_STATUS, d);
    chk("wide early", 8'h00, d);
    pulse(1); rd(dual_timer_pkg::ADDR_DATA0, d);
    chk("wide low", 8'h00, d);
    rd(dual_timer_pkg::ADDR_DATA1, d); chk("wide high", 8'h01, d);
    rd(dual_timer_pkg::ADDR_STATUS, d); chk("wide match", 8'h01, d);
    $display("test wide done");
    wr(dual_timer_pkg::ADDR_STATUS, 8'hFF);
    wr(dual_timer_pkg::ADDR_DATA1, 8'h03); trig1 <= 1'b1;
    m = $urandom_range(3, 40);
    // falling edge on the second input ends a divide-by-one run of m
    wr(dual_timer_pkg::ADDR_CTRL1, 8'h29);
    repeat (m) @(posedge clk_i);
    trig1 <= 1'b0;
    rd(dual_timer_pkg::ADDR_DATA1, d);
    chk("capture1", m[7:0], d);
    rd(dual_timer_pkg::ADDR_STATUS, d);
    chk("second_timer_capture_enable status", 8'h0A, d);
    wr(dual_timer_pkg::ADDR_CTRL0, 8'h21);
    repeat (2 * m) @(posedge clk_i);
    rd(dual_timer_pkg::ADDR_DATA0, d);
    // prescale phase is free running, so the count is m or m plus one
    chk("div2", 8'h00, (d - m[7:0]) & 8'hFE);
    $display("test second timer and prescale done");
    finish_test();
  end
endmodule : dual_8bit_timer_capture_test
